// ===== bench/mefw_host_model.sv
// Host-side model: writes packets to input channel 0 and drains output channel 3.
// Assumes one packet at a time and the same clock as the parameter block.
`timescale 1ns/1ps
`default_nettype none
module mefw_host_model (
    input  wire logic       clk,
    output logic            in_valid,
    output logic [7:0]      in_byte,
    output logic            in_last,
    input  wire logic       out_valid,
    input  wire logic [7:0] out_byte,
    input  wire logic       out_last,
    output logic            out_ready
);
    typedef logic [7:0] mefw_hq_t [$];

    initial begin
        in_valid  = 1'b0;
        in_byte   = 8'h00;
        in_last   = 1'b0;
        out_ready = 1'b0;
    end

    // Whole record in one burst, one byte a clock
    task automatic send_pkt(input mefw_hq_t b);
        foreach (b[i]) begin
            @(negedge clk);
            in_valid = 1'b1;
            in_byte  = b[i];
            in_last  = (i == b.size() - 1);
        end
        @(negedge clk);
        in_valid = 1'b0;
        // Idle line shows the inverse so a stale byte cannot pass for a fresh one
        in_byte  = ~in_byte;
        in_last  = 1'b0;
    endtask

    // Stall holds ready low for that many cycles before each byte
    task automatic recv_pkt(input int stall, output mefw_hq_t r, output bit ok);
        int gap;
        r   = {};
        ok  = 1'b0;
        gap = stall;
        for (int n = 0; n < 400 && !ok; n++) begin
            // Settled outputs are taken here; the handshake lands on the next rising edge
            @(negedge clk);
            out_ready = (gap == 0);
            if (out_ready && out_valid === 1'b1) begin
                r.push_back(out_byte);
                ok  = (out_last === 1'b1);
                gap = stall;
            end else if (gap > 0) begin
                gap--;
            end
            @(posedge clk);
        end
        @(negedge clk);
        out_ready = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== bench/mefw_param_block_bench.sv
// Self-checking bench for the meta-event and FIFO watermark parameter block.
// Assumes the host model feeds channel 0 and drains channel 3 on clk.
`timescale 1ns/1ps
`default_nettype none
`include "mefw_cfg.svh"
module mefw_param_block_bench;
    typedef logic [7:0] mefw_bq_t [$];
    localparam logic [31:0] wake_size  = `MEFW_WAKE_SIZE;
    localparam logic [31:0] nwake_size = `MEFW_NWAKE_SIZE;

    logic        clk, rst_b, in_valid, in_last, out_valid, out_last, out_ready;
    logic [7:0]  in_byte, out_byte;
    logic [1:0]  out_channel;
    logic [31:0] nwake_evt, wake_evt, nwake_evt_fifo, wake_evt_fifo;
    logic [31:0] wake_level, nwake_level, wake_wm, nwake_wm;
    logic        host_suspended_flag, all_low_latency, all_nonzero_latency;
    logic        wake_event_seen, host_irq;
    int          mismatches, comparisons;

    mefw_param_block dut (
        .clk                 (clk),
        .rst_b               (rst_b),
        .in_valid            (in_valid),
        .in_byte             (in_byte),
        .in_last             (in_last),
        .out_valid           (out_valid),
        .out_byte            (out_byte),
        .out_last            (out_last),
        .out_channel         (out_channel),
        .out_ready           (out_ready),
        .nwake_evt           (nwake_evt),
        .wake_evt            (wake_evt),
        .nwake_evt_fifo      (nwake_evt_fifo),
        .wake_evt_fifo       (wake_evt_fifo),
        .wake_level          (wake_level),
        .nwake_level         (nwake_level),
        .host_suspended_flag (host_suspended_flag),
        .all_low_latency     (all_low_latency),
        .all_nonzero_latency (all_nonzero_latency),
        .wake_event_seen     (wake_event_seen),
        .host_irq            (host_irq),
        .wake_wm             (wake_wm),
        .nwake_wm            (nwake_wm)
    );

    mefw_host_model host (
        .clk       (clk),
        .in_valid  (in_valid),
        .in_byte   (in_byte),
        .in_last   (in_last),
        .out_valid (out_valid),
        .out_byte  (out_byte),
        .out_last  (out_last),
        .out_ready (out_ready)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic mefw_bq_t le(input logic [63:0] v, input int n);
        mefw_bq_t q;
        for (int i = 0; i < n; i++) begin
            q.push_back(v[8*i +: 8]);
        end
        return q;
    endfunction

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] pid, input int len, input mefw_bq_t body);
        host.send_pkt({le(pid, 2), le(len, 2), body});
    endtask

    // Reply header echoes the parameter number and the body length
    task automatic rd(input logic [15:0] pid, input int stall, input mefw_bq_t body);
        mefw_bq_t r;
        mefw_bq_t exp;
        bit       ok;
        exp = {le(pid, 2), le(body.size(), 2), body};
        host.send_pkt({pid[7:0], pid[15:8] | 8'h10, 8'h00, 8'h00});
        host.recv_pkt(stall, r, ok);
        if (!ok) begin
            mismatches++;
            test_done();
        end else begin
            check("reply length", exp.size(), r.size());
            check("out_channel", 64'h3, out_channel);
            foreach (exp[i]) begin
                check($sformatf("reply byte %0d", i), exp[i], r[i]);
            end
        end
    endtask

    task automatic evt_step(input logic [31:0] n, w, nf, wf, input logic irq);
        @(negedge clk);
        nwake_evt = n;
        wake_evt  = w;
        #1;
        check("nwake_evt_fifo", nf, nwake_evt_fifo);
        check("wake_evt_fifo", wf, wake_evt_fifo);
        @(negedge clk);
        nwake_evt = 32'h0000_0000;
        wake_evt  = 32'h0000_0000;
        check("meta host_irq", irq, host_irq);
    endtask

    task automatic wm_step(input logic [31:0] wl, nl, input logic su, lo, nz, ws, irq);
        @(negedge clk);
        wake_level          = wl;
        nwake_level         = nl;
        host_suspended_flag = su;
        all_low_latency     = lo;
        all_nonzero_latency = nz;
        wake_event_seen     = ws;
        @(negedge clk);
        check("watermark host_irq", irq, host_irq);
    endtask

    initial begin
        mismatches          = 0;
        comparisons         = 0;
        rst_b               = 1'b0;
        nwake_evt           = 32'h0000_0000;
        wake_evt            = 32'h0000_0000;
        wake_level          = 32'h0000_0000;
        nwake_level         = 32'h0000_0000;
        host_suspended_flag = 1'b0;
        all_low_latency     = 1'b0;
        all_nonzero_latency = 1'b1;
        wake_event_seen     = 1'b0;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        check("host_irq", 64'h0, host_irq);
        check("out_valid", 64'h0, out_valid);
        check("wake_wm", 64'h0, wake_wm);
        rd(16'h0101, 0, le(`MEFW_META_DEFAULT, 8));
        wr(16'h0101, 8, le(64'h4000_0000_0000_0002, 8));
        wr(16'h0102, 8, le(64'hAAAA_AAAA_AAAA_AAAA, 8));
        rd(16'h0101, 0, le(64'h4000_0000_0000_0002, 8));
        rd(16'h0102, 2, le(64'hAAAA_AA2A_AAAA_AAAA, 8));
        // Short body against a length of 8 must leave the map alone
        wr(16'h0101, 8, le(64'hFFFF_FFFF_FFFF_FFFF, 7));
        rd(16'h0101, 0, le(64'h4000_0000_0000_0002, 8));
        evt_step(32'h0000_0001, 32'h0, 32'h0000_0001, 32'h0, 1'b0);
        evt_step(32'h8000_0000, 32'h0, 32'h0, 32'h0, 1'b1);
        evt_step(32'h0000_0002, 32'h0, 32'h0, 32'h0, 1'b0);
        evt_step(32'h0008_0000, 32'h0, 32'h0008_0000, 32'h0, 1'b0);
        evt_step(32'h0, 32'hFFFF_FFFF, 32'h0, 32'hFFFF_FFFF, 1'b0);
        // Low wake watermark, non-wake watermark above capacity
        wr(16'h0103, 16, {le(32'h10, 4), le(-1, 4), le(32'h1000, 4), le(-1, 4)});
        check("wake_wm", 64'h10, wake_wm);
        check("nwake_wm", 64'h1000, nwake_wm);
        rd(16'h0103, 1, {le(32'h10, 4), le(wake_size, 4), le(32'h1000, 4), le(nwake_size, 4)});
        wm_step(32'h0F, 32'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        wm_step(32'h10, 32'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        wm_step(32'h0, nwake_size - 1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        wm_step(32'h0, nwake_size, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        wm_step(32'h10, 32'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        wm_step(32'h10, 32'h0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        wm_step(32'h10, 32'h0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        wr(16'h0103, 16, {le(0, 8), le(0, 8)});
        check("wake_wm", 64'h0, wake_wm);
        check("nwake_wm", 64'h0, nwake_wm);
        wm_step(wake_size, nwake_size, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        wr(16'h0104, 20, {le(-1, 8), le(-1, 8), le(-1, 4)});
        rd(16'h0104, 0, {le(`MEFW_CUSTOM_VER, 2), le(`MEFW_HASH1, 6), le(`MEFW_HASH2, 6), le(`MEFW_USER_HASH, 6)});
        test_done();
    end
endmodule
`default_nettype wire

// ===== core/mefw_cfg.svh
// Constants for the meta-event and FIFO watermark parameter block.
// Assumes inclusion by bare name from design and bench files.
`ifndef MEFW_CFG_SVH
`define MEFW_CFG_SVH

`define MEFW_PID_NWAKE_META   16'h0101
`define MEFW_PID_WAKE_META    16'h0102
`define MEFW_PID_FIFO_CTRL    16'h0103
`define MEFW_PID_FW_VER       16'h0104
`define MEFW_RD_FLAG          16'h1000
`define MEFW_PID_MASK         16'h0FFF
`define MEFW_LEN_META         16'h0008
`define MEFW_LEN_FIFO         16'h0010
`define MEFW_LEN_VER          16'h0014
`define MEFW_HDR_BYTES        6'h04
`define MEFW_SPACER_IDX       5'h13
`define MEFW_OUT_CHANNEL      2'h3
`define MEFW_META_DEFAULT     64'h0000_0000_0000_0000
`define MEFW_WAKE_SIZE        32'h0000_0800
`define MEFW_NWAKE_SIZE       32'h0000_0800
`define MEFW_CUSTOM_VER       16'h0001
`define MEFW_HASH1            48'h0000_0000_0001
`define MEFW_HASH2            48'h0000_0000_0002
`define MEFW_USER_HASH        48'h0000_0000_0003
`define MEFW_OFF_WAKE_WM      6'h04
`define MEFW_OFF_NWAKE_WM     6'h0C

`endif

// ===== core/mefw_meta_gate.sv
// Applies one 64-bit meta-event map to a vector of event pulses.
// Assumes event pulses are single-cycle and on the block clock.
`timescale 1ns/1ps
`default_nettype none
`include "mefw_cfg.svh"
module mefw_meta_gate (
    input  wire logic [63:0] map,
    input  wire logic [31:0] evt,
    output logic [31:0]      evt_out,
    output logic             evt_irq
);
    wire logic [31:0] irq_each;
    genvar g;
    generate
        for (g = 0; g < 32; g = g + 1) begin : g_ev
            // Upper bit output enable, lower bit interrupt enable
            if (g == `MEFW_SPACER_IDX) begin : g_sp
                assign evt_out[g]  = evt[g];
                assign irq_each[g] = evt[g] & map[2*g];
            end else begin : g_nm
                assign evt_out[g]  = evt[g] & map[2*g+1];
                assign irq_each[g] = evt[g] & map[2*g];
            end
        end
    endgenerate
    assign evt_irq = |irq_each;
endmodule
`default_nettype wire

// ===== core/mefw_param_block.sv
// Parameter block for meta-event maps, FIFO watermarks and version record.
// Assumes a byte stream from the host input channel and a byte sink for output channel 3.
//
// Overview of operation
// - Parameter 0x0101 maps non-wake FIFO events, 0x0102 maps wake FIFO events.
// - Each map is eight writable bytes holding 32 two-bit entries.
// - Output enable forwards the event to FIFO; interrupt enable raises interrupt.
// - Upper entry bit is output enable, lower bit is interrupt enable.
// - Bitmap byte 4 holds events 1-4, lowest bits first, through byte 11.
// - Meta packet: id bytes 0-1, length 8 bytes 2-3, then bitmap.
// - Spacer event 20 always output-enabled yet read back as disabled.
// - Host interrupt asserts when FIFO byte count reaches its watermark.
// - Watermark zero disables watermark interrupts.
// - Watermark above capacity acts as equal to capacity.
// - Low latency sensors and host awake: latency drives interrupts, not watermark.
// - Watermark triggers only with nonzero latencies, or suspended without wake events.
// - FIFO record length 16: wake watermark, wake size, non-wake watermark, size.
// - FIFO sizes are fixed constants, readable, never writable.
// - Version record read-only, length 20, custom version at bytes 4-5.
// - Three six-byte hashes at bytes 6, 12 and 18.
// - Requested record is returned through output channel 3.
`timescale 1ns/1ps
`default_nettype none
`include "mefw_cfg.svh"
module mefw_param_block (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        in_valid,
    input  wire logic [7:0]  in_byte,
    input  wire logic        in_last,
    output logic             out_valid,
    output logic [7:0]       out_byte,
    output logic             out_last,
    output logic [1:0]       out_channel,
    input  wire logic        out_ready,
    input  wire logic [31:0] nwake_evt,
    input  wire logic [31:0] wake_evt,
    output logic [31:0]      nwake_evt_fifo,
    output logic [31:0]      wake_evt_fifo,
    input  wire logic [31:0] wake_level,
    input  wire logic [31:0] nwake_level,
    input  wire logic        host_suspended_flag,
    input  wire logic        all_low_latency,
    input  wire logic        all_nonzero_latency,
    input  wire logic        wake_event_seen,
    output logic             host_irq,
    output logic [31:0]      wake_wm,
    output logic [31:0]      nwake_wm
);
    mefw_pkg::mefw_state_t state_q, state_d;
    logic [63:0] nwake_map_q, wake_map_q;
    logic [31:0] wake_wm_q, nwake_wm_q;
    logic [15:0] cmd_q;
    logic [15:0] len_q;
    logic [5:0]  idx_q;
    logic [63:0] shadow_q;
    logic [7:0]  out_byte_q;
    logic        out_valid_q;
    logic        out_last_q;

    wire logic [15:0] pid;
    wire logic        is_read;
    wire logic        sel_nwake;
    wire logic        sel_wake;
    wire logic        sel_fifo;
    wire logic        sel_ver;
    wire logic [5:0]  body_idx;
    wire logic [15:0] rec_len;
    wire logic [5:0]  rec_end;
    wire logic [7:0]  rd_byte;
    wire logic        hdr_done;
    wire logic        body_done;
    wire logic        wake_hit;
    wire logic        nwake_hit;
    wire logic        wm_gate;
    wire logic        nwake_ev_irq;
    wire logic        wake_ev_irq;
    wire logic        out_fire;
    wire logic [5:0]  next_idx;
    wire logic [5:0]  rd_body;
    wire logic [7:0]  rd_byte_next;

    // Readback copy with the spacer entry forced to zero
    function automatic logic [63:0] mefw_read_map(input logic [63:0] m);
        logic [63:0] r;
        r = m;
        r[2*`MEFW_SPACER_IDX]   = 1'b0;
        r[2*`MEFW_SPACER_IDX+1] = 1'b0;
        return r;
    endfunction

    function automatic logic [7:0] mefw_byte32(input logic [31:0] w, input logic [1:0] b);
        logic [7:0] r;
        r = w[8*b +: 8];
        return r;
    endfunction

    assign pid       = cmd_q & `MEFW_PID_MASK;
    assign is_read   = (cmd_q & `MEFW_RD_FLAG) != 16'h0000;
    assign sel_nwake = (pid == `MEFW_PID_NWAKE_META);
    assign sel_wake  = (pid == `MEFW_PID_WAKE_META);
    assign sel_fifo  = (pid == `MEFW_PID_FIFO_CTRL);
    assign sel_ver   = (pid == `MEFW_PID_FW_VER);
    assign body_idx  = idx_q - `MEFW_HDR_BYTES;
    assign rec_len   = sel_ver ? `MEFW_LEN_VER : (sel_fifo ? `MEFW_LEN_FIFO : `MEFW_LEN_META);
    assign rec_end   = rec_len[5:0] + `MEFW_HDR_BYTES - 6'h01;
    assign hdr_done  = in_valid && (idx_q == `MEFW_HDR_BYTES - 6'h01);
    assign out_fire  = out_valid_q && out_ready;
    assign body_done = out_fire && out_last_q;

    // Record byte at the reply position about to be loaded, header included
    assign rd_body = next_idx - `MEFW_HDR_BYTES;
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (next_idx == 6'h00) begin
            rd_mux = pid[7:0];
        end else if (next_idx == 6'h01) begin
            rd_mux = pid[15:8];
        end else if (next_idx == 6'h02) begin
            rd_mux = rec_len[7:0];
        end else if (next_idx == 6'h03) begin
            rd_mux = rec_len[15:8];
        end else if (sel_nwake || sel_wake) begin
            rd_mux = shadow_q[8*rd_body[2:0] +: 8];
        end else if (sel_fifo) begin
            case (rd_body[3:2])
                2'h0: rd_mux = mefw_byte32(wake_wm_q, rd_body[1:0]);
                2'h1: rd_mux = mefw_byte32(`MEFW_WAKE_SIZE, rd_body[1:0]);
                2'h2: rd_mux = mefw_byte32(nwake_wm_q, rd_body[1:0]);
                2'h3: rd_mux = mefw_byte32(`MEFW_NWAKE_SIZE, rd_body[1:0]);
                default: rd_mux = 8'h00;
            endcase
        end else if (sel_ver) begin
            // Custom version then three six-byte hashes
            if (rd_body < 6'h02) begin
                rd_mux = 8'(`MEFW_CUSTOM_VER >> (8*rd_body));
            end else if (rd_body < 6'h08) begin
                rd_mux = 8'(`MEFW_HASH1 >> (8*(rd_body - 6'h02)));
            end else if (rd_body < 6'h0E) begin
                rd_mux = 8'(`MEFW_HASH2 >> (8*(rd_body - 6'h08)));
            end else if (rd_body < 6'h14) begin
                rd_mux = 8'(`MEFW_USER_HASH >> (8*(rd_body - 6'h0E)));
            end
        end
    end
    assign rd_byte = rd_mux;

    always_comb begin
        state_d = state_q;
        case (state_q)
            mefw_pkg::MEFW_IDLE: begin
                if (in_valid) begin
                    state_d = mefw_pkg::MEFW_HDR;
                end
            end
            mefw_pkg::MEFW_HDR: begin
                if (hdr_done) begin
                    state_d = is_read ? mefw_pkg::MEFW_REPLY : mefw_pkg::MEFW_BODY;
                end
                if (in_valid && in_last) begin
                    state_d = mefw_pkg::MEFW_IDLE;
                end
                if (hdr_done && is_read) begin
                    state_d = mefw_pkg::MEFW_REPLY;
                end
            end
            mefw_pkg::MEFW_BODY: begin
                if (in_valid && in_last) begin
                    state_d = mefw_pkg::MEFW_IDLE;
                end
            end
            mefw_pkg::MEFW_REPLY: begin
                if (body_done) begin
                    state_d = mefw_pkg::MEFW_IDLE;
                end
            end
            default: state_d = mefw_pkg::MEFW_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= mefw_pkg::MEFW_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Header capture and byte index
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_q <= 16'h0000;
            len_q <= 16'h0000;
            idx_q <= 6'h00;
        end else if (state_q == mefw_pkg::MEFW_REPLY) begin
            if (out_fire) begin
                idx_q <= out_last_q ? 6'h00 : idx_q + 6'h01;
            end
        end else if (in_valid) begin
            case (idx_q)
                6'h00: cmd_q[7:0]  <= in_byte;
                6'h01: cmd_q[15:8] <= in_byte;
                6'h02: len_q[7:0]  <= in_byte;
                6'h03: len_q[15:8] <= in_byte;
                default: ;
            endcase
            // Reads restart the index for the reply; writes run to the end
            if (in_last || (hdr_done && is_read)) begin
                idx_q <= 6'h00;
            end else if (idx_q != 6'h3F) begin
                idx_q <= idx_q + 6'h01;
            end
        end
    end

    // Meta-map record write lands in a shadow, committed only on a full transfer
    wire logic body_wr;
    assign body_wr = in_valid && (state_q == mefw_pkg::MEFW_BODY);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shadow_q <= 64'h0000_0000_0000_0000;
        end else if (hdr_done && is_read) begin
            shadow_q <= sel_wake ? mefw_read_map(wake_map_q) : mefw_read_map(nwake_map_q);
        end else if (body_wr && (body_idx < 6'h08)) begin
            shadow_q[8*body_idx[2:0] +: 8] <= in_byte;
        end
    end

    wire logic commit;
    assign commit = body_wr && in_last && (idx_q == rec_end) && (len_q == rec_len);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nwake_map_q <= `MEFW_META_DEFAULT;
            wake_map_q  <= `MEFW_META_DEFAULT;
        end else if (commit && sel_nwake) begin
            nwake_map_q <= {in_byte, shadow_q[55:0]};
        end else if (commit && sel_wake) begin
            wake_map_q <= {in_byte, shadow_q[55:0]};
        end
    end

    // Only watermark words are writable; size and version bytes are dropped
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_wm_q  <= 32'h0000_0000;
            nwake_wm_q <= 32'h0000_0000;
        end else if (body_wr && sel_fifo) begin
            if ({idx_q[5:2], 2'b00} == `MEFW_OFF_WAKE_WM) begin
                wake_wm_q[8*idx_q[1:0] +: 8] <= in_byte;
            end else if ({idx_q[5:2], 2'b00} == `MEFW_OFF_NWAKE_WM) begin
                nwake_wm_q[8*idx_q[1:0] +: 8] <= in_byte;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_valid_q <= 1'b0;
            out_byte_q  <= 8'h00;
            out_last_q  <= 1'b0;
        end else if (state_d == mefw_pkg::MEFW_REPLY && (!out_valid_q || out_ready)) begin
            out_valid_q <= !(out_fire && out_last_q);
            out_byte_q  <= rd_byte_next;
            out_last_q  <= next_idx == rec_end;
        end else if (out_fire) begin
            out_valid_q <= 1'b0;
        end
    end

    // Reply entry starts at byte 0, whatever index the header left behind
    assign next_idx     = (state_q != mefw_pkg::MEFW_REPLY) ? 6'h00 :
                          (out_fire ? idx_q + 6'h01 : idx_q);
    assign rd_byte_next = rd_byte;

    assign out_valid   = out_valid_q;
    assign out_byte    = out_byte_q;
    assign out_last    = out_last_q;
    assign out_channel = `MEFW_OUT_CHANNEL;

    mefw_meta_gate u_nwake_gate (
        .map     (nwake_map_q),
        .evt     (nwake_evt),
        .evt_out (nwake_evt_fifo),
        .evt_irq (nwake_ev_irq)
    );
    mefw_meta_gate u_wake_gate (
        .map     (wake_map_q),
        .evt     (wake_evt),
        .evt_out (wake_evt_fifo),
        .evt_irq (wake_ev_irq)
    );
    mefw_wm_check u_wake_wm (
        .watermark (wake_wm_q),
        .capacity  (`MEFW_WAKE_SIZE),
        .level     (wake_level),
        .wm_hit    (wake_hit)
    );
    mefw_wm_check u_nwake_wm (
        .watermark (nwake_wm_q),
        .capacity  (`MEFW_NWAKE_SIZE),
        .level     (nwake_level),
        .wm_hit    (nwake_hit)
    );

    // Latency scheduling owns the interrupt while the host is awake on low latency
    assign wm_gate = !(all_low_latency && !host_suspended_flag) &&
                     (all_nonzero_latency || (host_suspended_flag && !wake_event_seen));

    logic irq_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= nwake_ev_irq || wake_ev_irq ||
                     (wm_gate && (wake_hit || nwake_hit));
        end
    end
    assign host_irq = irq_q;
    assign wake_wm  = wake_wm_q;
    assign nwake_wm = nwake_wm_q;

    AST_EVT_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
        (wake_ev_irq || nwake_ev_irq) |=> host_irq) else $error("event irq lost");
    AST_SPACER: assert property (@(posedge clk) disable iff (!rst_b)
        wake_evt[`MEFW_SPACER_IDX] |-> wake_evt_fifo[`MEFW_SPACER_IDX])
        else $error("spacer dropped");
    AST_WM_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
        (wake_wm_q == 32'h0) |-> !wake_hit) else $error("zero wm fired");
    AST_WM_CAP: assert property (@(posedge clk) disable iff (!rst_b)
        (nwake_wm_q > `MEFW_NWAKE_SIZE && nwake_level >= `MEFW_NWAKE_SIZE) |-> nwake_hit)
        else $error("cap clamp failed");
    AST_LOWLAT: assert property (@(posedge clk) disable iff (!rst_b)
        (all_low_latency && !host_suspended_flag) |-> !wm_gate)
        else $error("wm active on low latency");
    AST_WM_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
        (wm_gate && nwake_hit) |=> host_irq) else $error("wm irq missing");
    AST_OUT_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        (out_valid && !out_ready) |=> (out_valid && $stable(out_byte) && $stable(out_last)))
        else $error("reply byte not held");
    AST_RO_SIZE: assert property (@(posedge clk) disable iff (!rst_b)
        (body_wr && sel_fifo && idx_q[5:2] == 4'h2) |=> $stable(wake_wm_q))
        else $error("size write leaked");
endmodule
`default_nettype wire

// ===== core/mefw_pkg.sv
// Types for the meta-event and FIFO watermark parameter block.
// Assumes the cfg header supplies every numeric constant.
package mefw_pkg;
    typedef enum logic [3:0] {
        MEFW_IDLE = 4'h1,
        MEFW_HDR  = 4'h2,
        MEFW_BODY = 4'h4,
        MEFW_REPLY = 4'h8
    } mefw_state_t;
endpackage

// ===== core/mefw_wm_check.sv
// Watermark comparator for one FIFO.
// Assumes level and watermark come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module mefw_wm_check (
    input  wire logic [31:0] watermark,
    input  wire logic [31:0] capacity,
    input  wire logic [31:0] level,
    output logic             wm_hit
);
    wire logic [31:0] eff_wm;
    // Oversized watermark behaves as capacity
    assign eff_wm = (watermark > capacity) ? capacity : watermark;
    // Zero disables the trigger
    assign wm_hit = (watermark != 32'h0000_0000) && (level >= eff_wm);
endmodule
`default_nettype wire
